// file: rtl/rxq_qualifier.sv
// receive-port video qualifier: checks raw video, derives pass, filters output
// assumes clk is the pixel clock; raw pixel inputs and lock are pins, synchronised here
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "rxq_cfg.svh"

module rxq_qualifier (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire rxq_pkg::rxq_pix_t pix_in,
  input wire logic rx_lock,
  input wire logic raw10_mode,
  input wire logic parity_error,
  input wire logic freeze_detect,
  input wire logic new_image,
  input wire logic link_clk_mhz_vld,
  input wire logic [7:0] link_clk_mhz,
  output rxq_pkg::rxq_out_t pix_out,
  output logic qualified,
  output logic clock_too_slow,
  output logic irq
);
  import rxq_pkg::*;

  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0] mbox0;
  logic [7:0] mbox1;
  logic [7:0] rawopt;
  logic [7:0] fwdctl;
  logic [3:0] clock_low_limit_mhz;
  logic [4:0] istat;
  logic [4:0] imask;
  logic [4:0] ev;
  logic [7:0] idx;
  logic bus_req;
  logic wr;
  logic ack_q;
  logic rx_lock_s;

  assign idx = wb_adr_i[9:2];
  assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
  // write lands on the ack edge, while the master still holds the request,
  // so software never sees a register change before its cycle completes
  assign wr = wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_sel_i[0] && ce;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else if (ce) begin
      ack_q <= bus_req;
    end
  end
  assign wb_ack_o = ack_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mbox0 <= `RXQ_MBOX0_RST;
      mbox1 <= `RXQ_MBOX1_RST;
      rawopt <= `RXQ_RAWOPT_RST;
      fwdctl <= `RXQ_FWDCTL_RST;
      clock_low_limit_mhz <= `RXQ_FREQ_LO_RST;
      imask <= 5'h00;
    end else if (wr) begin
      unique case (idx)
        `RXQ_IDX_MBOX0: mbox0 <= wb_dat_i[7:0]; // see RL2
        `RXQ_IDX_MBOX1: mbox1 <= wb_dat_i[7:0]; // see RL2
        `RXQ_IDX_RAWOPT: rawopt <= wb_dat_i[7:0] & 8'hfb;
        `RXQ_IDX_FWDCTL: fwdctl <= wb_dat_i[7:0];
        `RXQ_IDX_FREQ: clock_low_limit_mhz <= wb_dat_i[3:0];
        `RXQ_IDX_IMASK: imask <= wb_dat_i[4:0];
        default: ;
      endcase
    end
  end

  // sticky status, set beats write-one-to-clear
  logic [4:0] w1c;
  assign w1c = (wr && idx == `RXQ_IDX_ISTAT) ? wb_dat_i[4:0] : 5'h00;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      istat <= 5'h00;
    end else if (ce) begin
      istat <= (istat & ~w1c) | ev;
    end
  end
  assign irq = |(istat & imask);

  // read data is registered with the ack
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_dat_o <= 32'h0;
    end else if (ce && bus_req) begin
      unique case (idx)
        `RXQ_IDX_MBOX0: wb_dat_o <= {24'h0, mbox0};
        `RXQ_IDX_MBOX1: wb_dat_o <= {24'h0, mbox1};
        `RXQ_IDX_RAWOPT: wb_dat_o <= {24'h0, rawopt};
        `RXQ_IDX_FWDCTL: wb_dat_o <= {24'h0, fwdctl};
        `RXQ_IDX_STATUS: wb_dat_o <= {29'h0, clock_too_slow, rx_lock_s, qualified};
        `RXQ_IDX_ISTAT: wb_dat_o <= {27'h0, istat};
        `RXQ_IDX_IMASK: wb_dat_o <= {27'h0, imask};
        `RXQ_IDX_FREQ: wb_dat_o <= {28'h0, clock_low_limit_mhz};
        default: wb_dat_o <= 32'h0;
      endcase
    end
  end

  // ************************************************************
  // input synchronisers
  // ************************************************************
  // measured rate rides the same two flops as its valid, so both settle together
  localparam int SW = 26;
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  logic [SW-1:0] sin;
  assign sin = {pix_in.frame_marker, pix_in.line_marker, pix_in.data, rx_lock, raw10_mode,
                parity_error, freeze_detect, new_image, link_clk_mhz_vld, link_clk_mhz};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1 <= '0;
      sync2 <= '0;
    end else if (ce) begin
      sync1 <= sin;
      sync2 <= sync1;
    end
  end
  logic fm_raw;
  logic lm_raw;
  logic [9:0] dat_s;
  logic raw10_s;
  logic par_s;
  logic frz_s;
  logic newimg_s;
  logic mhz_vld_s;
  logic [7:0] mhz_s;
  assign {fm_raw, lm_raw, dat_s, rx_lock_s, raw10_s, par_s, frz_s, newimg_s, mhz_vld_s, mhz_s} = sync2;

  // measurement word is only sampled on its synchronised valid
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clock_too_slow <= 1'b0;
    end else if (ce && mhz_vld_s) begin
      clock_too_slow <= mhz_s < {4'h0, clock_low_limit_mhz}; // see RL1
    end
  end

  // ************************************************************
  // marker decode and size tracking
  // ************************************************************
  logic frame_marker;
  logic line_marker;
  logic fm_d;
  logic lm_d;
  assign frame_marker = fm_raw ^ rawopt[`RXQ_F_FRAME_LVL]; // see RL8
  assign line_marker = lm_raw ^ rawopt[`RXQ_F_LINE_LVL]; // see RL7
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fm_d <= 1'b0;
      lm_d <= 1'b0;
    end else if (ce) begin
      fm_d <= frame_marker;
      lm_d <= line_marker;
    end
  end
  logic sof;
  logic eof;
  logic eol;
  assign sof = frame_marker && !fm_d;
  assign eof = !frame_marker && fm_d;
  assign eol = !line_marker && lm_d;

  logic [15:0] pix_cnt;
  logic [15:0] line_len;
  logic [15:0] line_cnt;
  logic [15:0] frame_lines;
  logic len_seen;
  logic hgt_seen;
  logic lsz_chg;
  logic hgt_chg;
  assign lsz_chg = eol && frame_marker && len_seen && (pix_cnt != line_len);
  assign hgt_chg = eof && hgt_seen && (line_cnt != frame_lines);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pix_cnt <= 16'h0;
      line_len <= 16'h0;
      line_cnt <= 16'h0;
      frame_lines <= 16'h0;
      len_seen <= 1'b0;
      hgt_seen <= 1'b0;
    end else if (ce) begin
      if (line_marker && frame_marker) begin
        pix_cnt <= pix_cnt + 16'h1;
      end else begin
        pix_cnt <= 16'h0;
      end
      if (eol && frame_marker) begin
        line_len <= pix_cnt;
        len_seen <= 1'b1;
        line_cnt <= line_cnt + 16'h1;
      end
      if (sof) begin
        line_cnt <= 16'h0;
      end
      if (eof) begin
        frame_lines <= line_cnt;
        hgt_seen <= 1'b1;
      end
      if (!rx_lock_s) begin
        len_seen <= 1'b0;
        hgt_seen <= 1'b0;
      end
    end
  end

  // ************************************************************
  // frame watchdog
  // ************************************************************
  logic [23:0] period;
  logic [23:0] period_cnt;
  logic [24:0] wd_cnt;
  logic wd_fire;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      period <= 24'h0;
      period_cnt <= 24'h0;
      wd_cnt <= 25'h0;
    end else if (ce) begin
      period_cnt <= sof ? 24'h1 : period_cnt + {23'h0, period_cnt != 24'hffffff};
      if (sof && period_cnt != 24'h0) begin
        period <= period_cnt;
      end
      if (eof || !rx_lock_s || wd_fire) begin
        wd_cnt <= 25'h0;
      end else if (period != 24'h0) begin
        wd_cnt <= wd_cnt + 25'h1;
      end
    end
  end
  // two measured frame periods without any frame end, clean or not
  assign wd_fire = !fwdctl[`RXQ_F_WDOG_OFF] && (fwdctl[`RXQ_F_THR] != 2'h0) &&
                   (period != 24'h0) && (wd_cnt >= {period, 1'b0}); // see RL14

  // ************************************************************
  // qualification
  // ************************************************************
  logic frame_bad;
  logic par_pulse;
  logic drop;
  logic frz_wait;
  logic [1:0] vcnt;
  rxq_state_t state;
  logic chk_frz;
  assign chk_frz = fwdctl[`RXQ_F_CHK_FRZ];
  assign par_pulse = par_s && !fwdctl[`RXQ_F_PAR_MODE]; // see RL13
  assign drop = (chk_frz && frz_s) // see RL10
             || (fwdctl[`RXQ_F_CHK_HGT] && hgt_chg) // see RL11
             || (fwdctl[`RXQ_F_CHK_LSZ] && lsz_chg) // see RL12
             || (fwdctl[`RXQ_F_PAR_MODE] && par_s) // see RL13
             || (rawopt[`RXQ_F_TRUNC_FSZ] && hgt_chg) // see RL6
             || wd_fire;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frame_bad <= 1'b0;
    end else if (ce) begin
      if (sof) begin
        frame_bad <= 1'b0;
      end else if (par_s || lsz_chg) begin
        frame_bad <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= RXQ_WAIT_LOCK;
      vcnt <= 2'h0;
      frz_wait <= 1'b0;
    end else if (ce) begin
      if (!rx_lock_s) begin
        state <= RXQ_WAIT_LOCK; // see RL16
        vcnt <= 2'h0;
        frz_wait <= 1'b0;
      end else if (drop) begin
        state <= RXQ_COUNTING; // see RL16
        vcnt <= 2'h0;
        frz_wait <= chk_frz && frz_s;
      end else begin
        if (newimg_s) begin
          frz_wait <= 1'b0;
        end
        unique case (state)
          RXQ_WAIT_LOCK: begin
            state <= (fwdctl[`RXQ_F_THR] == 2'h0) ? RXQ_PASSING : RXQ_COUNTING; // see RL15
          end
          RXQ_COUNTING: begin
            if (eof && !frame_bad && !frz_wait) begin
              if (vcnt + 2'h1 >= fwdctl[`RXQ_F_THR]) begin
                state <= RXQ_PASSING; // see RL15
              end else begin
                vcnt <= vcnt + 2'h1;
              end
            end else if (fwdctl[`RXQ_F_THR] == 2'h0 && !frz_wait) begin
              state <= RXQ_PASSING;
            end
          end
          RXQ_PASSING: ;
        endcase
      end
    end
  end
  assign qualified = (state == RXQ_PASSING) && !par_pulse;

  // ************************************************************
  // output filter
  // ************************************************************
  logic trunc;
  logic pass_ok;
  logic [9:0] odata;
  assign trunc = (rawopt[`RXQ_F_TRUNC_PAR] && par_s) // see RL4
              || (rawopt[`RXQ_F_TRUNC_LSZ] && lsz_chg) // see RL5
              || (rawopt[`RXQ_F_TRUNC_FSZ] && state != RXQ_PASSING); // see RL6
  assign pass_ok = !fwdctl[`RXQ_F_DISC_EN] || qualified; // see RL9

  // reserved packing code falls back to normal handling
  always_comb begin
    odata = dat_s;
    if (raw10_s) begin
      unique case (rxq_pack_t'(rawopt[`RXQ_F_PACK])) // see RL3
        RXQ_PACK_UPPER: odata = {2'h0, dat_s[9:2]};
        RXQ_PACK_LOWER: odata = {2'h0, dat_s[7:0]};
        RXQ_PACK_NORMAL: odata = dat_s;
        RXQ_PACK_RSVD: odata = dat_s;
      endcase
    end
  end

  logic cut;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cut <= 1'b0;
      pix_out <= '0;
    end else if (ce) begin
      if (sof) begin
        cut <= !pass_ok;
      end else if (trunc || !pass_ok) begin
        cut <= 1'b1;
      end
      pix_out.valid <= frame_marker && line_marker && !cut && !trunc && pass_ok;
      pix_out.sof <= sof && pass_ok;
      pix_out.eol <= eol && frame_marker && !cut && pass_ok;
      pix_out.eof <= eof && !cut;
      pix_out.data <= odata;
    end
  end

  assign ev = {wd_fire, clock_too_slow && mhz_vld_s, lsz_chg, hgt_chg, par_s};
endmodule

// file: rtl/rxq_cfg.svh
// register offsets, field positions, reset values and timing counts
// assumes a classic wishbone slave with 32-bit data, one register per word
//
// Behaviour
// RL1 - the port flags its incoming clock as too slow when the measured rate in MHz is below a programmable limit that resets to 5.
// RL2 - two scratch mailbox bytes read and write freely with no side effect, resetting to zero and to one.
// RL3 - with raw10 input a 2-bit selector picks normal 10-bit (00), upper eight bits (10) or lower eight bits (11), 01 reserved.
// RL4 - with parity truncation set, a frame holding a parity error is truncated, otherwise it is forwarded.
// RL5 - with line-size truncation set, a change in line size truncates the frame, otherwise it is tolerated.
// RL6 - with frame-size truncation set, a change in line count truncates the packet until the frame threshold is met again.
// RL7 - line marker level 1 means the line marker is low while active, 0 means high.
// RL8 - frame marker level 1 means the frame marker is low for the whole frame, 0 means high.
// RL9 - with qualified-discard set, packets are dropped while the port is not qualified, otherwise forwarded regardless.
// RL10 - with freeze checking on, a frozen image clears qualification until a new image is seen and the threshold is met.
// RL11 - with height checking on, a change in lines per frame clears qualification until the threshold is met again.
// RL12 - with line-size checking on, a change in line size clears qualification until the threshold is met again.
// RL13 - parity mode 0 drops qualification only for the cycle of each error, mode 1 holds it clear until the threshold is met.
// RL14 - unless disabled, a watchdog clears qualification when no valid frame end comes within two frame periods, and is idle at threshold zero.
// the code restarts the watchdog on any frame end, valid or not.
// RL15 - a 2-bit threshold sets how many valid frames are needed, zero qualifies as soon as lock is seen.
// RL16 - the valid-frame counter clears on loss of lock or when qualification drops, then counts up to the threshold.
`ifndef RXQ_CFG_SVH
`define RXQ_CFG_SVH

`define RXQ_IDX_MBOX0 8'h78
`define RXQ_IDX_MBOX1 8'h79
`define RXQ_IDX_RAWOPT 8'h7c
`define RXQ_IDX_FWDCTL 8'h7d
`define RXQ_IDX_STATUS 8'h80
`define RXQ_IDX_ISTAT 8'h81
`define RXQ_IDX_IMASK 8'h82
`define RXQ_IDX_FREQ 8'h83

`define RXQ_MBOX0_RST 8'h00
`define RXQ_MBOX1_RST 8'h01
`define RXQ_RAWOPT_RST 8'h00
`define RXQ_FWDCTL_RST 8'h00
`define RXQ_FREQ_LO_RST 4'h5

// raw option fields
`define RXQ_F_PACK 7:6
`define RXQ_F_TRUNC_PAR 5
`define RXQ_F_TRUNC_LSZ 4
`define RXQ_F_TRUNC_FSZ 3
`define RXQ_F_LINE_LVL 1
`define RXQ_F_FRAME_LVL 0
// forward control fields
`define RXQ_F_DISC_EN 7
`define RXQ_F_CHK_FRZ 6
`define RXQ_F_CHK_HGT 5
`define RXQ_F_CHK_LSZ 4
`define RXQ_F_PAR_MODE 3
`define RXQ_F_WDOG_OFF 2
`define RXQ_F_THR 1:0

// one-microsecond gate at 20 MHz for clock measurement
`define RXQ_GATE_NS 1000
`define RXQ_CLK_NS 50
`define RXQ_GATE_CYC (`RXQ_GATE_NS / `RXQ_CLK_NS)

`endif

// file: rtl/rxq_pkg.sv
// types shared by the qualifier and its users
// assumes rxq_cfg.svh supplies the numbers
package rxq_pkg;
  typedef struct packed {
    logic frame_marker;
    logic line_marker;
    logic [9:0] data;
  } rxq_pix_t;

  typedef struct packed {
    logic valid;
    logic sof;
    logic eol;
    logic eof;
    logic [9:0] data;
  } rxq_out_t;

  typedef enum logic [1:0] {
    RXQ_PACK_NORMAL,
    RXQ_PACK_RSVD,
    RXQ_PACK_UPPER,
    RXQ_PACK_LOWER
  } rxq_pack_t;

  typedef enum {
    RXQ_WAIT_LOCK,
    RXQ_COUNTING,
    RXQ_PASSING
  } rxq_state_t;
endpackage

// file: tb/rxq_chk.sv
// assertion checker for rxq_qualifier, bound to its top-level ports
// assumes one clock and the register indices of the design
`timescale 1ns/1ps
module rxq_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic rx_lock,
  input wire logic parity_error,
  input wire logic link_clk_mhz_vld,
  input wire logic [7:0] link_clk_mhz,
  input wire rxq_pkg::rxq_out_t pix_out,
  input wire logic qualified,
  input wire logic clock_too_slow,
  input wire logic irq
);
  import rxq_pkg::*;
  logic [7:0] fwd;
  logic [7:0] msk;
  logic [3:0] lim;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ****************
  // register shadows
  // ****************
  // follow acked writes only, as the slave does
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fwd <= 8'h00;
      msk <= 8'h00;
      lim <= 4'h5;
    end else if (wb_ack_o && wb_we_i && wb_cyc_i && wb_stb_i && wb_sel_i[0]) begin
      if (wb_adr_i[9:2] == 8'h7d) fwd <= wb_dat_i[7:0];
      if (wb_adr_i[9:2] == 8'h82) msk <= wb_dat_i[7:0];
      if (wb_adr_i[9:2] == 8'h83) lim <= wb_dat_i[3:0];
    end
  end
  // **********
  // properties
  // **********
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
  endsequence
  // two sync flops plus the state update
  sequence s_lock_gone;
    (!rx_lock && ce) [*4];
  endsequence
  sequence s_rate_low;
    (link_clk_mhz_vld && ce && link_clk_mhz < {4'h0, lim}) [*6];
  endsequence
  a_ack_after_take: assert property (s_take |=> wb_ack_o)
    else $error("no ack after take");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than a cycle");
  a_unlock_clears: assert property (s_lock_gone |-> !qualified)
    else $error("qualified without lock");
  a_slow_flag_set: assert property (s_rate_low |-> clock_too_slow)
    else $error("slow clock not flagged");
  a_slow_flag_clear: assert property ((link_clk_mhz_vld && ce && link_clk_mhz >= {4'h0, lim}) [*6] |-> !clock_too_slow)
    else $error("fast clock flagged slow");
  a_irq_fully_masked: assert property ((msk == 8'h00) [*2] |-> !irq)
    else $error("irq while masked");
  a_drop_unqualified: assert property ((fwd[7] && !qualified) [*2] |=> !pix_out.valid)
    else $error("pixel passed while unqualified");
  a_zero_thr_pass: assert property ((fwd[6:3] == 4'h0 && fwd[1:0] == 2'h0 && rx_lock && !parity_error && ce) [*5] |-> qualified)
    else $error("no pass at zero threshold");
endmodule

bind rxq_qualifier rxq_chk i_chk (.*);

// file: tb/rxq_cam.sv
// camera-side model: raw video frames into the qualifier's pixel pins
// assumes the bench calls its tasks in the clk domain
`timescale 1ns/1ps
module rxq_cam (
  input wire logic clk,
  output rxq_pkg::rxq_pix_t pix
);
  import rxq_pkg::*;
  logic line_lvl = 1'b0;
  logic frame_lvl = 1'b0;
  initial pix = '0;
  // *******
  // drivers
  // *******
  // idle markers sit at the level the polarity setting names
  task automatic levels(input logic l, input logic f);
    @(posedge clk);
    line_lvl = l;
    frame_lvl = f;
    pix.line_marker <= l;
    pix.frame_marker <= f;
  endtask
  // blank data toggles so stale pixels never look valid
  task automatic frame(input int lines, input int len, input int gap);
    @(posedge clk);
    pix.frame_marker <= ~frame_lvl;
    repeat (3) @(posedge clk);
    for (int l = 0; l < lines; l++) begin
      for (int p = 0; p < len; p++) begin
        pix.line_marker <= ~line_lvl;
        pix.data <= 10'(l * 32 + p);
        @(posedge clk);
      end
      pix.line_marker <= line_lvl;
      repeat (gap) begin
        pix.data <= ~pix.data;
        @(posedge clk);
      end
    end
    pix.frame_marker <= frame_lvl;
    repeat (6) begin
      pix.data <= ~pix.data;
      @(posedge clk);
    end
  endtask
endmodule

// file: tb/tb_top.sv
// self-checking bench for rxq_qualifier
// assumes rxq_cam as video source and the bound checker
`timescale 1ns/1ps
module tb_top;
  import rxq_pkg::*;
  logic clk, rst, we, cyc, stb, ack, lock, raw10, par, vld, qual, slow, irq;
  logic [31:0] adr, wdat, rdat, rd;
  logic [7:0] mhz;
  rxq_pix_t pix;
  rxq_out_t pout;
  int fails = 0;
  int n_tests = 0;
  int nv = 0;
  int ns = 0;
  int ne = 0;
  int nl = 0;
  logic [9:0] ld;
  rxq_qualifier i_dut (.clk(clk), .rst(rst), .ce(1'b1), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .pix_in(pix),
    .rx_lock(lock), .raw10_mode(raw10), .parity_error(par), .freeze_detect(1'b0), .new_image(1'b0),
    .link_clk_mhz_vld(vld), .link_clk_mhz(mhz), .pix_out(pout), .qualified(qual),
    .clock_too_slow(slow), .irq(irq));
  rxq_cam i_cam (.clk(clk), .pix(pix));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // non-blocking so scenario snapshots never race the count
  always @(posedge clk) begin
    if (pout.valid === 1'b1) nv <= nv + 1;
    if (pout.sof === 1'b1) ns <= ns + 1;
    if (pout.eof === 1'b1) ne <= ne + 1;
    if (pout.eol === 1'b1) nl <= nl + 1;
    if (pout.valid === 1'b1) ld <= pout.data;
  end
  // *************
  // shared tasks
  // *************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= {22'h0, a, 2'h0};
    wdat <= {24'h0, d};
    we <= w;
    cyc <= 1'b1;
    stb <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    chkb(ack, 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(rd, {24'h0, e});
  endtask
  task automatic wq(input logic e);
    for (int i = 0; i < 12 && qual !== e; i++) @(posedge clk);
    chkb(qual, e);
  endtask
  // *********
  // scenarios
  // *********
  task automatic t_regs();
    rchk(8'h78, 8'h00);
    rchk(8'h79, 8'h01);
    rchk(8'h83, 8'h05);
    rchk(8'h7d, 8'h00);
    wr(8'h78, 8'ha5);
    wr(8'h79, 8'h5a);
    rchk(8'h78, 8'ha5);
    rchk(8'h79, 8'h5a);
    rchk(8'h90, 8'h00);
    wr(8'h7c, 8'hff);
    rchk(8'h7c, 8'hfb);
    wr(8'h7c, 8'h00);
  endtask
  task automatic t_frames();
    int v, s, e, l;
    lock <= 1'b1;
    wq(1'b1);
    raw10 <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(8'h7c, 8'(i * 65));
      i_cam.levels(i[1], i[0]);
      repeat (8) @(posedge clk);
      v = nv;
      s = ns;
      e = ne;
      l = nl;
      i_cam.frame(4, 8, 2 + 4 * i);
      chk(nv - v, 32'h20);
      chk(nl - l, 32'h4);
      chk({22'h0, ld}, (i == 2) ? 32'h19 : 32'h67);
      chk(ns - s, 32'h1);
      chk(ne - e, 32'h1);
    end
    wr(8'h7c, 8'h00);
    i_cam.levels(1'b0, 1'b0);
    raw10 <= 1'b0;
    repeat (300) @(posedge clk);
    chkb(qual, 1'b1);
  endtask
  task automatic t_thresh();
    wr(8'h7d, 8'h02);
    lock <= 1'b0;
    wq(1'b0);
    lock <= 1'b1;
    i_cam.frame(4, 8, 2);
    chkb(qual, 1'b0);
    i_cam.frame(4, 8, 2);
    i_cam.frame(4, 8, 2);
    wq(1'b1);
    repeat (300) @(posedge clk);
    chkb(qual, 1'b0);
  endtask
  task automatic t_height();
    int v;
    wr(8'h7d, 8'ha5);
    i_cam.frame(4, 8, 2);
    i_cam.frame(4, 8, 2);
    wq(1'b1);
    i_cam.frame(6, 8, 2);
    chkb(qual, 1'b0);
    v = nv;
    i_cam.frame(6, 8, 2);
    chk(nv - v, 32'h0);
    wq(1'b1);
    wr(8'h7d, 8'h27);
    lock <= 1'b0;
    wq(1'b0);
    lock <= 1'b1;
    v = nv;
    i_cam.frame(4, 8, 2);
    chk(nv - v, 32'h20);
  endtask
  task automatic t_parity();
    wr(8'h7d, 8'h04);
    wq(1'b1);
    par <= 1'b1;
    wq(1'b0);
    par <= 1'b0;
    wq(1'b1);
    wr(8'h7d, 8'h0d);
    par <= 1'b1;
    repeat (3) @(posedge clk);
    par <= 1'b0;
    repeat (20) @(posedge clk);
    chkb(qual, 1'b0);
    i_cam.frame(4, 8, 2);
    wq(1'b1);
  endtask
  task automatic t_irq();
    wr(8'h7d, 8'h04);
    wr(8'h81, 8'hff);
    rchk(8'h81, 8'h00);
    wr(8'h82, 8'h08);
    mhz <= 8'h04;
    vld <= 1'b1;
    repeat (10) @(posedge clk);
    chkb(slow, 1'b1);
    chkb(irq, 1'b1);
    rchk(8'h81, 8'h08);
    wr(8'h82, 8'h00);
    repeat (2) @(posedge clk);
    chkb(irq, 1'b0);
    wr(8'h83, 8'h04);
    repeat (10) @(posedge clk);
    chkb(slow, 1'b0);
    wr(8'h81, 8'h08);
    rchk(8'h81, 8'h00);
  endtask
  task automatic complete_run();
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // all scenarios take under 2000 cycles; allow ten times that
  initial begin
    #1000000;
    fails++;
    complete_run();
  end
  initial begin
    rst = 1'b1;
    adr = 32'h0;
    wdat = 32'h0;
    we = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    lock = 1'b0;
    raw10 = 1'b0;
    par = 1'b0;
    vld = 1'b0;
    mhz = 8'h32;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_frames();
    t_thresh();
    t_height();
    t_parity();
    t_irq();
    complete_run();
  end
endmodule
